// File: design/status_readout_map.svh
// Purpose: Offsets, field positions and reset values of the status readout.
// Assumes: Word addresses are the four-bit codes carried in the top of each word.
// Notes: Definitions only.
`ifndef STATUS_READOUT_MAP_SVH
`define STATUS_READOUT_MAP_SVH
`define ADDR_INIT1 4'h0
`define ADDR_QUICK 4'h1
`define ADDR_CH1 4'h2
`define ADDR_CH4 4'h5
`define ADDR_DEVSTAT 4'h7
`define ADDR_LIVE 4'h8
`define ADDR_PARTID 4'h9
`define ADDR_SENSE_CTRL 4'hA
`define FRAME_BITS 5'h10
`define SEL_RESET 4'h1
`define PERSIST_RESET 1'b0
`define ROUTE_RESET 3'h0
`define SENSE_EN_RESET 4'h0
`define INIT_PERSIST_BIT 4
`define INIT_ROUTE_LSB 5
`define ROUTE_LAST_CHANNEL 3'h3
`endif

// File: design/status_readout_pkg.sv
// Purpose: Types shared by the status readout.
// Assumes: Constants live in status_readout_map.svh.
// Notes: Types only.
package status_readout_pkg;
  typedef struct packed {
    logic ots;
    logic otw;
    logic oc_valid;
    logic [2:0] oc_code;
    logic olon;
    logic oloff;
  } chan_evt_t;
  typedef struct packed {
    logic ots;
    logic otw;
    logic [2:0] oc_code;
    logic olon;
    logic oloff;
  } chan_stat_t;
  typedef struct packed {
    logic uv;
    logic ov;
    logic charge_pump_fault;
    logic clock_fail_flag;
    logic test_mode_flag;
    logic serial_fail_flag;
  } dev_evt_t;
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b01,
    FRAME_SHIFT = 2'b10
  } frame_state_t;
endpackage

// File: design/spi_diagnostic_status_readout.sv
// Purpose: Fault and status readout of a four-channel high-side switch over a 16-bit serial link.
// Assumes: Fault events are one-cycle pulses and live levels are deglitched, both on clk.
// Notes: Serial pins are sampled by clk through two flip-flops.
// Behaviour
// - The four-bit read select field in init register zero picks the returned word.
// - Without persistence the programmed address serves one read, then quick status returns.
// - With persistence the programmed address serves every read until reprogrammed.
// - Every word carries its address on top; address zero returns quick status as 0001.
// - Bit 11 of every word shows fail mode.
// - Summary flags in bits 10..8 appear in all words except live and identification, clearing once all latched faults are read.
// - Device summary is the OR of cleared, voltage, pump, clock and test flags.
// - Overload summary ORs all overcurrent and shutdown; open load sits in bit 8.
// - Quick status bit 6 is set when all serial registers were reset.
// - Quick bits 3..0 OR each channel's overcurrent, thermal and open-load flags.
// - Channel word layout: shutdown 6, warning 5, code 4..2, open-load 1 and 0.
// - The overcurrent code holds the latest event, overwriting an unread one.
// - Device word: test 4, overvoltage 3, undervoltage 2, serial fail 1, limp 0.
// - The limp-home bit is live and never latched.
// - Live word shows toggle OR in 9, inputs in 8..5, comparators in 3..0.
// - Comparator bits are only valid without undervoltage.
// - Identification word returns the part code, reading zero under undervoltage.
// - A three-bit field routes feedback, which is off in fail and sleep modes.
// - Current feedback is off during inrush and while the switch is off.
// - Precision sense enables reset to zero, are forced off in fail mode.
// - Precision sense toggles offset sign per strobe rise and halves range and threshold.
// - Latched channel faults clear only by reading that channel's word.
`timescale 1ns/1ps
`default_nettype none
`include "status_readout_map.svh"
module spi_diagnostic_status_readout
  import status_readout_pkg::*;
#(
  // Part code value is arbitrary.
  parameter logic [7:0] PART_CODE = 8'h5A
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  input wire logic fail_mode,
  input wire logic sleep_mode,
  input wire chan_evt_t [3:0] chan_evt,
  input wire dev_evt_t dev_evt,
  input wire logic limp_home_input_state,
  input wire logic [3:0] control_input_state,
  input wire logic [3:0] toggle_state,
  input wire logic [3:0] output_comparator_state,
  input wire logic [3:0] inrush_window,
  input wire logic [3:0] switch_on,
  input wire logic feedback_sample_strobe,
  output logic [2:0] feedback_route_field,
  output logic feedback_enable,
  output logic [3:0] precision_sense_mode,
  output logic [3:0] offset_sign,
  output logic [3:0] half_range
);

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  logic [2:0] sclk_ff;
  logic [2:0] cs_ff;
  logic [1:0] mosi_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_ff <= 3'h0;
      cs_ff <= 3'h7;
      mosi_ff <= 2'h0;
    end else begin
      sclk_ff <= {sclk_ff[1:0], sclk};
      cs_ff <= {cs_ff[1:0], cs_n};
      mosi_ff <= {mosi_ff[0], mosi};
    end
  end

  assign sclk_rise = sclk_ff[1] & ~sclk_ff[2];
  assign sclk_fall = ~sclk_ff[1] & sclk_ff[2];
  assign cs_fall = ~cs_ff[1] & cs_ff[2];
  assign cs_rise = cs_ff[1] & ~cs_ff[2];

  // ----------------------------------------
  // Frame shifting
  // ----------------------------------------
  frame_state_t state_ff;
  logic [4:0] bit_cnt_ff;
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  logic [3:0] rd_addr_ff;
  logic miso_ff;
  logic [15:0] word;
  logic [3:0] rd_tag;
  logic frame_end;
  logic frame_ok;
  logic wr_init;
  logic wr_sense;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= FRAME_IDLE;
    end else begin
      case (state_ff)
        FRAME_IDLE: if (cs_fall) state_ff <= FRAME_SHIFT;
        FRAME_SHIFT: if (cs_rise) state_ff <= FRAME_IDLE;
        default: state_ff <= FRAME_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt_ff <= 5'h0;
      rx_ff <= 16'h0000;
    end else if (state_ff == FRAME_IDLE && cs_fall) begin
      bit_cnt_ff <= 5'h0;
    end else if (state_ff == FRAME_SHIFT && sclk_rise) begin
      rx_ff <= {rx_ff[14:0], mosi_ff[1]};
      if (bit_cnt_ff != 5'h1F) bit_cnt_ff <= bit_cnt_ff + 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_ff <= 16'h0000;
      miso_ff <= 1'b0;
      rd_addr_ff <= `SEL_RESET;
    end else if (state_ff == FRAME_IDLE && cs_fall) begin
      tx_ff <= word;
      miso_ff <= word[15];
      rd_addr_ff <= rd_tag;
    end else if (state_ff == FRAME_SHIFT && sclk_fall) begin
      tx_ff <= {tx_ff[14:0], 1'b0};
      miso_ff <= tx_ff[14];
    end
  end

  assign miso_o = miso_ff;
  assign miso_oe = (state_ff == FRAME_SHIFT);
  assign frame_end = (state_ff == FRAME_SHIFT) && cs_rise;
  assign frame_ok = frame_end && (bit_cnt_ff == `FRAME_BITS);
  assign wr_init = frame_ok && (rx_ff[15:12] == `ADDR_INIT1);
  assign wr_sense = frame_ok && (rx_ff[15:12] == `ADDR_SENSE_CTRL);

  // ----------------------------------------
  // Read selection and init register
  // ----------------------------------------
  logic [3:0] sel_ff;
  logic persist_ff;
  logic pending_ff;
  logic used_ff;
  logic [2:0] route_ff;
  logic [3:0] sense_en_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      used_ff <= 1'b0;
    end else if (state_ff == FRAME_IDLE && cs_fall) begin
      used_ff <= pending_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_ff <= `SEL_RESET;
      persist_ff <= `PERSIST_RESET;
      pending_ff <= 1'b0;
      route_ff <= `ROUTE_RESET;
    end else if (wr_init) begin
      sel_ff <= rx_ff[3:0];
      persist_ff <= rx_ff[`INIT_PERSIST_BIT];
      pending_ff <= ~rx_ff[`INIT_PERSIST_BIT];
      route_ff <= rx_ff[`INIT_ROUTE_LSB+2:`INIT_ROUTE_LSB];
    end else if (frame_end && used_ff) begin
      sel_ff <= `SEL_RESET;
      pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sense_en_ff <= `SENSE_EN_RESET;
    end else if (wr_sense) begin
      sense_en_ff <= rx_ff[3:0];
    end
  end

  // ----------------------------------------
  // Latched faults
  // ----------------------------------------
  chan_stat_t [3:0] ch_ff;
  dev_evt_t dev_ff;
  logic rcf_ff;
  logic rd_dev;
  logic [3:0] rd_ch;

  assign rd_dev = frame_ok && (rd_addr_ff == `ADDR_DEVSTAT);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      assign rd_ch[g] = frame_ok && (rd_addr_ff == `ADDR_CH1 + 4'(g));
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ch_ff[g] <= '0;
        end else begin
          ch_ff[g].ots <= chan_evt[g].ots | (ch_ff[g].ots & ~rd_ch[g]);
          ch_ff[g].otw <= chan_evt[g].otw | (ch_ff[g].otw & ~rd_ch[g]);
          ch_ff[g].olon <= chan_evt[g].olon | (ch_ff[g].olon & ~rd_ch[g]);
          ch_ff[g].oloff <= chan_evt[g].oloff | (ch_ff[g].oloff & ~rd_ch[g]);
          if (chan_evt[g].oc_valid) begin
            ch_ff[g].oc_code <= chan_evt[g].oc_code;
          end else if (rd_ch[g]) begin
            ch_ff[g].oc_code <= 3'h0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dev_ff <= '0;
    end else begin
      dev_ff <= dev_evt | (dev_ff & {6{~rd_dev}});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcf_ff <= 1'b1;
    end else if (rd_dev) begin
      rcf_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Word assembly
  // ----------------------------------------
  logic device_fault_summary;
  logic overload_summary;
  logic openload_summary;
  logic [3:0] qsf;
  logic [3:0] sense_sel;
  logic [2:0] flags;

  always_comb begin
    overload_summary = 1'b0;
    openload_summary = 1'b0;
    for (int i = 0; i < 4; i++) begin
      qsf[i] = (|ch_ff[i].oc_code) | ch_ff[i].otw | ch_ff[i].ots | ch_ff[i].olon | ch_ff[i].oloff;
      overload_summary = overload_summary | (|ch_ff[i].oc_code) | ch_ff[i].ots;
      openload_summary = openload_summary | ch_ff[i].olon | ch_ff[i].oloff;
    end
  end

  assign device_fault_summary = rcf_ff | dev_ff.uv | dev_ff.ov | dev_ff.charge_pump_fault | dev_ff.clock_fail_flag | dev_ff.test_mode_flag;
  assign flags = {device_fault_summary, overload_summary, openload_summary};
  assign rd_tag = (sel_ff == `ADDR_INIT1) ? `ADDR_QUICK : sel_ff;

  always_comb begin
    word = {rd_tag, fail_mode, flags, 8'h00};
    if (rd_tag == `ADDR_QUICK) begin
      word[7:0] = {dev_ff.charge_pump_fault, rcf_ff, dev_ff.clock_fail_flag, 1'b0, qsf};
    end else if (rd_tag >= `ADDR_CH1 && rd_tag <= `ADDR_CH4) begin
      word[7:0] = {1'b0, ch_ff[2'(rd_tag - `ADDR_CH1)]};
    end else if (rd_tag == `ADDR_DEVSTAT) begin
      word[7:0] = {3'h0, dev_ff.test_mode_flag, dev_ff.ov, dev_ff.uv, dev_ff.serial_fail_flag, limp_home_input_state};
    end else if (rd_tag == `ADDR_LIVE) begin
      word[10:0] = {1'b0, |toggle_state, control_input_state, 1'b0,
                    output_comparator_state & {4{~dev_ff.uv}}};
    end else if (rd_tag == `ADDR_PARTID) begin
      word[10:0] = {3'h0, dev_ff.uv ? 8'h00 : PART_CODE};
    end else begin
      word[10:8] = flags;
    end
  end

  // ----------------------------------------
  // Analog feedback and precision sense
  // ----------------------------------------
  logic strobe_ff;
  logic [3:0] sign_ff;
  logic cur_ok;

  assign sense_sel = 4'h1 << route_ff[1:0];
  assign cur_ok = |(sense_sel & switch_on & ~inrush_window);
  assign feedback_route_field = route_ff;
  assign feedback_enable = ~fail_mode & ~sleep_mode & ((route_ff > `ROUTE_LAST_CHANNEL) | cur_ok);
  assign precision_sense_mode = sense_en_ff & {4{~fail_mode}};
  assign half_range = precision_sense_mode;
  assign offset_sign = sign_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_ff <= 1'b0;
      sign_ff <= 4'h0;
    end else begin
      strobe_ff <= feedback_sample_strobe;
      if (feedback_sample_strobe & ~strobe_ff) begin
        sign_ff <= sign_ff ^ precision_sense_mode;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fm_every_word: assert property (word[11] == fail_mode)
    else $error("fail mode bit wrong");
  a_frame_snapshot: assert property (state_ff == FRAME_IDLE && cs_fall |=> tx_ff == $past(word)
    && tx_ff[15:12] != `ADDR_INIT1)
    else $error("frame word not the selected one");
  a_oneshot_revert: assert property (frame_end && used_ff && !wr_init |=> sel_ff == `SEL_RESET)
    else $error("single read did not revert");
  a_persist_hold: assert property (frame_end && !used_ff && !wr_init |=> $stable(sel_ff))
    else $error("persistent select changed");
  a_select_write: assert property (wr_init |=> sel_ff == $past(rx_ff[3:0]))
    else $error("select not written");
  a_chan_clear: assert property (rd_ch[0] && !chan_evt[0].ots |=> !ch_ff[0].ots)
    else $error("channel fault not cleared");
  a_set_wins: assert property (chan_evt[0].ots |=> ch_ff[0].ots ##1 ch_ff[0].ots || $past(rd_ch[0]))
    else $error("fault event lost");
  a_oc_latest: assert property (chan_evt[1].oc_valid |=> ch_ff[1].oc_code == $past(chan_evt[1].oc_code))
    else $error("overcurrent code not latest");
  a_id_uv_zero: assert property (dev_ff.uv && rd_tag == `ADDR_PARTID |-> word[7:0] == 8'h00)
    else $error("part code shown under undervoltage");
  a_fb_fail_off: assert property (fail_mode || sleep_mode
    |-> !feedback_enable && (!fail_mode || precision_sense_mode == 4'h0))
    else $error("feedback active in fail or sleep");
  a_sign_toggle: assert property (feedback_sample_strobe && !strobe_ff && precision_sense_mode[0]
    |=> offset_sign[0] != $past(offset_sign[0]))
    else $error("offset sign did not toggle");

endmodule // spi_diagnostic_status_readout
`default_nettype wire

// File: tb/host_link_model.sv
// Purpose: Host side of the serial status link.
// Assumes: Link clock of 160 ns that idles low outside frames.
// Notes: Between frames the data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_o
);
  // ----
  // Frame engine.
  // ----
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Sends one whole word MSB first and samples the reply on each rise.
  task automatic xfer(input logic [15:0] si, output logic [15:0] so);
    cs_n = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      mosi = si[i];
      #80 sclk = 1'b1;
      so[i] = miso_o;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    mosi = ~mosi;
    #80;
  endtask
endmodule // host_link_model
`default_nettype wire

// File: tb/spi_diagnostic_status_readout_test.sv
// Purpose: Self-checking bench of the status readout.
// Assumes: The host model drives the serial pins.
// Notes: Fault events are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module spi_diagnostic_status_readout_test import status_readout_pkg::*;;
  // ----
  // Signals and instances.
  // ----
  localparam logic [7:0] CODE = 8'h3C; // Arbitrary value.
  logic clk, rst_n, sclk, cs_n, mosi, miso_o, miso_oe;
  logic fail_mode, sleep_mode, limp, strobe, fb_en;
  chan_evt_t [3:0] chan_evt;
  dev_evt_t dev_evt;
  logic [3:0] ctl, tgl, cmp, inrush, sw_on, psm, osign, half;
  logic [2:0] route;
  int n_fail = 0;
  int comparisons = 0;

  host_link_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o));

  spi_diagnostic_status_readout #(.PART_CODE(CODE)) DUT (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .fail_mode(fail_mode),
    .sleep_mode(sleep_mode), .chan_evt(chan_evt), .dev_evt(dev_evt),
    .limp_home_input_state(limp), .control_input_state(ctl),
    .toggle_state(tgl), .output_comparator_state(cmp),
    .inrush_window(inrush), .switch_on(sw_on),
    .feedback_sample_strobe(strobe), .feedback_route_field(route),
    .feedback_enable(fb_en), .precision_sense_mode(psm),
    .offset_sign(osign), .half_range(half)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----
  // Shared tasks.
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] si, input logic [15:0] exp);
    logic [15:0] so;
    @(posedge clk) #1;
    u_host.xfer(si, so);
    check(so, exp);
  endtask

  task automatic do_reset();
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic pulse_chan(input chan_evt_t [3:0] e);
    @(posedge clk) #1 chan_evt = e;
    @(posedge clk) #1 chan_evt = '0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----
  // Scenarios.
  // ----
  task automatic t_quick();
    rd(16'h1000, 16'h1440);
    check(16'(miso_oe), 16'h0);
    rd(16'h0000, 16'h1440);
    rd(16'h1000, 16'h1440);
  endtask

  task automatic t_one_shot();
    @(posedge clk) #1 limp = 1'b1;
    rd(16'h0007, 16'h1440);
    rd(16'h1000, 16'h7401);
    @(posedge clk) #1 limp = 1'b0;
    rd(16'h1000, 16'h1000);
  endtask

  task automatic t_channel();
    pulse_chan(32'h0000_2400);
    pulse_chan(32'h0000_7881);
    rd(16'h1000, 16'h1303);
    rd(16'h0013, 16'h1303);
    rd(16'h1000, 16'h3338);
    rd(16'h1000, 16'h3300);
    rd(16'h0012, 16'h3300);
    rd(16'h1000, 16'h2341);
    rd(16'h1000, 16'h2000);
  endtask

  task automatic t_device();
    @(posedge clk) #1 dev_evt = 6'h22;
    @(posedge clk) #1 dev_evt = '0;
    rd(16'h0019, 16'h2400);
    rd(16'h1000, 16'h9000);
    rd(16'h0017, 16'h9000);
    rd(16'h1000, 16'h7414);
    do_reset();
    #1 {ctl, tgl, cmp, fail_mode} = {4'hA, 4'h2, 4'h5, 1'b1};
    rd(16'h0018, 16'h1C40);
    rd(16'h1000, 16'h8B45);
    @(posedge clk) #1 fail_mode = 1'b0;
    rd(16'h0009, 16'h8345);
    rd(16'h1000, {8'h90, CODE});
  endtask

  task automatic t_feedback();
    rd(16'h00A1, 16'h1440);
    check(16'(route), 16'h5);
    check(16'(fb_en), 16'h1);
    @(posedge clk) #1 sleep_mode = 1'b1;
    #1 check(16'(fb_en), 16'h0);
    @(posedge clk) #1 sleep_mode = 1'b0;
    rd(16'h0021, 16'h1440);
    @(posedge clk) #1 sw_on = 4'h2;
    #1 check(16'(fb_en), 16'h1);
    @(posedge clk) #1 inrush = 4'h2;
    #1 check(16'(fb_en), 16'h0);
  endtask

  task automatic t_sense();
    check(16'(psm), 16'h0);
    rd(16'hA005, 16'h1440);
    check(16'(psm), 16'h5);
    check(16'(half), 16'h5);
    @(posedge clk) #1 strobe = 1'b1;
    repeat (4) @(posedge clk);
    check(16'(osign), 16'h5);
    #1 fail_mode = 1'b1;
    #1 check(16'(psm), 16'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    {fail_mode, sleep_mode, limp, strobe} = '0;
    {ctl, tgl, cmp, inrush, sw_on} = '0;
    chan_evt = '0;
    dev_evt = '0;
    do_reset();
    t_quick();
    t_one_shot();
    t_channel();
    t_device();
    t_feedback();
    t_sense();
    tally_and_finish();
  end

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule // spi_diagnostic_status_readout_test
`default_nettype wire
